// File: core/dmov_consts.svh
// Constants of the dual-group data mover: register offsets, entry fields,
// reset values. Assumes a 16-bit register port address and 32-bit words.
//
// Overview of operation
// - Both address units run transfers at once when their slaves differ.
// - High unit wins slave contention, then low unit, before other masters.
// - Each event state bit mirrors the level of its event input.
// - Flag latches rising or falling edge, polarity chosen per event.
// - Each event is high or low group and starts a transfer or interrupt.
// - High unit serves only high-group events; low unit only low-group events.
// - Each group's parameter memory holds event entries and transfer entries.
// - Event entry binds transfer with a transfer pointer, or an interrupt.
// - Each transfer entry table holds at most eight entries.
// - Interrupt-bound event raises the CPU interrupt named in its entry.
// - Event entry holds type, sync, reload, element size and pointer.
// - Transfer entry holds source, destination, count and address indexes.
// - Entries live in the parameter memory of the event's own group.
// - Flags capture 31 events; an encoder orders pending events by priority.
// - One event per group is processed at a time, both groups concurrently.
// - CPU trigger register toggles appear as ordinary event edges.
// - Trigger bits 0,16,1,17,2,18,3,19,20,21 map to events 0,1,10,11,17,18,23,24,30,31.
// - Timer, audio, host port, SPI and I2C events have fixed numbers.
// - Event 25 reserved; 26-28 audio error ORs; 29 timer overflow error.
`ifndef DMOV_CONSTS_SVH
`define DMOV_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses on the register port)
`define DMOV_OFF_POL     16'h0008
`define DMOV_OFF_EN_SET  16'h000c
`define DMOV_OFF_EN_CLR  16'h0010
`define DMOV_OFF_HI_SET  16'h0014
`define DMOV_OFF_LO_SET  16'h0018
`define DMOV_OFF_FLAG    16'h001c
`define DMOV_OFF_STATE   16'h0034
`define DMOV_OFF_TRIG    16'h0038
`define DMOV_OFF_DONE    16'h0080
`define DMOV_OFF_STATUS  16'h0084
// Parameter memory window: addr[15:9] selects it, addr[8] the group
`define DMOV_PMEM_PAGE   7'h08

// ==========================================================
// Event entry fields
`define DMOV_EE_TYPE     1:0
`define DMOV_EE_SYNC     3:2
`define DMOV_EE_RELOAD   4
`define DMOV_EE_ESIZE    6:5
`define DMOV_EE_PTR      10:8
`define DMOV_EE_IRQ      15:12
`define DMOV_TYPE_XFER   2'h1
`define DMOV_TYPE_INT    2'h2

// ==========================================================
// Transfer entry words and fields
`define DMOV_TE_SRC      2'h0
`define DMOV_TE_DST      2'h1
`define DMOV_TE_CNT      2'h2
`define DMOV_TE_IDX      2'h3
`define DMOV_TE_SIDX     15:0
`define DMOV_TE_DIDX     31:16
`define DMOV_TE_COUNT    15:0
// Crossbar slave port is chosen by the top address nibble
`define DMOV_SLV_SEL     31:28

// ==========================================================
// Reset values
`define DMOV_RST_WORD    32'h0000_0000
`define DMOV_RST_IRQ     16'h0000

`endif

// File: core/dmov_pkg.sv
// Types of the dual-group data mover.
// Assumes the constants header is included by the design files.
package dmov_pkg;

    // ==========================================================
    // Address unit states, Gray along the transfer path
    typedef enum logic [2:0] {
        DMOV_IDLE  = 3'h0,
        DMOV_EVT   = 3'h1,
        DMOV_LOAD  = 3'h3,
        DMOV_READ  = 3'h2,
        DMOV_WRITE = 3'h6,
        DMOV_FIN   = 3'h7
    } dmov_state_t;

    // ==========================================================
    // Crossbar master command
    typedef struct packed {
        logic we;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dmov_mcmd_t;

    // ==========================================================
    // Peripheral event inputs, all levels
    typedef struct packed {
        logic [3:0] timer_request;
        logic [2:0] audio_tx_req;
        logic [2:0] audio_rx_req;
        logic host_port_interrupt;
        logic [1:0] spi_rx_req;
        logic [1:0] i2c_tx_evt;
        logic [1:0] i2c_rx_evt;
        logic [2:0] audio_mute_input;
        logic [2:0] audio_tx_err;
        logic [2:0] audio_rx_err;
        logic timer_overflow_error;
    } dmov_evin_t;

endpackage

// File: core/dmov_top.sv
// Dual-group data mover: event capture, encoder, two parameter memories
// and two address units, each a master on the peripheral crossbar.
// Assumes synchronous event inputs and a crossbar that acks held requests.
//
// Chosen here: the placing of the registers and strobed register access.
`include "dmov_consts.svh"

module dmov_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire dmov_pkg::dmov_evin_t evin,
    output logic [1:0] mst_req,
    output dmov_pkg::dmov_mcmd_t mst_cmd_hi,
    output dmov_pkg::dmov_mcmd_t mst_cmd_lo,
    input wire logic [1:0] mst_ack,
    input wire logic [31:0] mst_rdata_hi,
    input wire logic [31:0] mst_rdata_lo,
    output logic [15:0] cpu_irq
);
    import dmov_pkg::*;

    // ==========================================================
    // Functions

    // Lowest set bit wins; returns {valid, index}
    function automatic logic [5:0] first_bit(input logic [31:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 31; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, 5'(i)};
            end
        end
        return r;
    endfunction

    // Address step: signed element index scaled by element size
    function automatic logic [31:0] addr_step(input logic [15:0] idx,
                                              input logic [1:0] esize);
        logic [31:0] s;
        s = {{16{idx[15]}}, idx};
        return s << esize;
    endfunction

    // One-hot of an event number
    function automatic logic [31:0] ev_bit(input logic [4:0] n);
        return 32'h0000_0001 << n;
    endfunction

    // ==========================================================
    // Declarations
    logic [31:0] soft_trigger_reg;
    logic [31:0] ev_raw;
    logic [31:0] event_state_reg;
    logic [31:0] state_prev;
    logic [31:0] polarity;
    logic [31:0] enable;
    logic [31:0] high_group;
    logic [31:0] event_flag_reg;
    logic [31:0] done_reg;
    logic [31:0] edge_set;
    logic [31:0] disp_clr;
    logic [31:0] fin_set;
    logic [31:0] fin_dis;
    logic [31:0] parameter_memory [0:127];
    logic pmem_hit;
    logic [6:0] pmem_idx;
    logic [31:0] pend [2];
    logic [5:0] pick [2];
    logic dispatch [2];
    dmov_state_t st [2];
    logic [4:0] ev_num [2];
    logic [31:0] ee [2];
    logic [6:0] te_base [2];
    logic [31:0] src [2];
    logic [31:0] dst [2];
    logic [15:0] cnt [2];
    logic [15:0] sidx [2];
    logic [15:0] didx [2];
    logic [1:0] esize [2];
    logic [1:0] sync_type [2];
    logic reload [2];
    logic [31:0] data [2];
    dmov_mcmd_t cmd [2];
    logic [31:0] rdata_in [2];
    logic lo_blocked;

    // ==========================================================
    // Event sources

    // Fixed event numbering of peripherals and trigger bits
    always_comb begin
        ev_raw = 32'h0000_0000;
        ev_raw[0] = soft_trigger_reg[0];
        ev_raw[1] = soft_trigger_reg[16];
        ev_raw[2] = evin.timer_request[0];
        ev_raw[3] = evin.timer_request[1];
        for (int p = 0; p < 3; p++) begin
            ev_raw[4 + 2 * p] = evin.audio_tx_req[p];
            ev_raw[5 + 2 * p] = evin.audio_rx_req[p];
            ev_raw[26 + p] = evin.audio_mute_input[p] | evin.audio_tx_err[p]
                           | evin.audio_rx_err[p];
        end
        ev_raw[10] = soft_trigger_reg[1];
        ev_raw[11] = soft_trigger_reg[17];
        ev_raw[12] = evin.host_port_interrupt;
        ev_raw[13] = evin.spi_rx_req[0];
        ev_raw[14] = evin.spi_rx_req[1];
        ev_raw[15] = evin.timer_request[2];
        ev_raw[16] = evin.timer_request[3];
        ev_raw[17] = soft_trigger_reg[2];
        ev_raw[18] = soft_trigger_reg[18];
        ev_raw[19] = evin.i2c_tx_evt[0];
        ev_raw[20] = evin.i2c_rx_evt[0];
        ev_raw[21] = evin.i2c_tx_evt[1];
        ev_raw[22] = evin.i2c_rx_evt[1];
        ev_raw[23] = soft_trigger_reg[3];
        ev_raw[24] = soft_trigger_reg[19];
        ev_raw[25] = 1'b0;
        ev_raw[29] = evin.timer_overflow_error;
        ev_raw[30] = soft_trigger_reg[20];
        ev_raw[31] = soft_trigger_reg[21];
    end

    // State register mirrors the inputs, previous copy for edges
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            event_state_reg <= `DMOV_RST_WORD;
            state_prev <= `DMOV_RST_WORD;
        end else begin
            event_state_reg <= ev_raw;
            state_prev <= event_state_reg;
        end
    end

    // Polarity 0 takes rising edges, 1 takes falling edges
    assign edge_set = ((event_state_reg & ~state_prev & ~polarity)
                    | (~event_state_reg & state_prev & polarity))
                    & enable;

    // ==========================================================
    // Software-written control

    // Trigger, polarity and group registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            soft_trigger_reg <= `DMOV_RST_WORD;
            polarity <= `DMOV_RST_WORD;
            high_group <= `DMOV_RST_WORD;
        end else if (reg_wr) begin
            case (reg_addr)
                `DMOV_OFF_TRIG: soft_trigger_reg <= reg_wdata;
                `DMOV_OFF_POL: polarity <= reg_wdata;
                `DMOV_OFF_HI_SET: high_group <= high_group | reg_wdata;
                `DMOV_OFF_LO_SET: high_group <= high_group & ~reg_wdata;
                default: ;
            endcase
        end
    end

    // Enables: set and clear by software, one-shot events disabled at end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            enable <= `DMOV_RST_WORD;
        end else if (reg_wr && reg_addr == `DMOV_OFF_EN_SET) begin
            enable <= (enable & ~fin_dis) | reg_wdata;
        end else if (reg_wr && reg_addr == `DMOV_OFF_EN_CLR) begin
            enable <= enable & ~fin_dis & ~reg_wdata;
        end else begin
            enable <= enable & ~fin_dis;
        end
    end

    // Flags: edges set, dispatch or software write-one clears, set wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            event_flag_reg <= `DMOV_RST_WORD;
        end else if (reg_wr && reg_addr == `DMOV_OFF_FLAG) begin
            event_flag_reg <= (event_flag_reg & ~disp_clr & ~reg_wdata) | edge_set;
        end else begin
            event_flag_reg <= (event_flag_reg & ~disp_clr) | edge_set;
        end
    end

    // Transfer complete bits, write one to clear, completion wins
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            done_reg <= `DMOV_RST_WORD;
        end else if (reg_wr && reg_addr == `DMOV_OFF_DONE) begin
            done_reg <= (done_reg & ~reg_wdata) | fin_set;
        end else begin
            done_reg <= done_reg | fin_set;
        end
    end

    // ==========================================================
    // Parameter memories: 32 event entries then 8 four-word transfer entries

    // Group 0 is high, group 1 is low; window word index spans both groups
    assign pmem_hit = reg_addr[15:9] == `DMOV_PMEM_PAGE;
    assign pmem_idx = reg_addr[8:2];

    // Software fills entries before enabling events
    always_ff @(posedge mclk) begin
        if (reg_wr && pmem_hit) begin
            parameter_memory[pmem_idx] <= reg_wdata;
        end
    end

    // Entry lookups for each unit from its own group's memory
    always_comb begin
        for (int u = 0; u < 2; u++) begin
            ee[u] = parameter_memory[{1'(u), 1'b0, ev_num[u]}];
            te_base[u] = {1'(u), 1'b1, ee[u][`DMOV_EE_PTR], 2'h0};
        end
    end

    // ==========================================================
    // Event encoder

    // Lowest pending number of each group goes to that group's idle unit
    always_comb begin
        pend[0] = event_flag_reg & high_group;
        pend[1] = event_flag_reg & ~high_group;
        disp_clr = 32'h0000_0000;
        for (int u = 0; u < 2; u++) begin
            pick[u] = first_bit(pend[u]);
            dispatch[u] = st[u] == DMOV_IDLE && pick[u][5];
            if (dispatch[u]) begin
                disp_clr = disp_clr | ev_bit(pick[u][4:0]);
            end
        end
    end

    // Completion marks and one-shot disables
    always_comb begin
        fin_set = 32'h0000_0000;
        fin_dis = 32'h0000_0000;
        for (int u = 0; u < 2; u++) begin
            if (st[u] == DMOV_FIN) begin
                fin_set = fin_set | ev_bit(ev_num[u]);
                if (!reload[u]) begin
                    fin_dis = fin_dis | ev_bit(ev_num[u]);
                end
            end
        end
    end

    // ==========================================================
    // Address units

    // Low unit holds off while the high unit requests the same slave
    assign lo_blocked = mst_req[0] && !mst_ack[0]
                     && cmd[0].addr[`DMOV_SLV_SEL] == cmd[1].addr[`DMOV_SLV_SEL];
    assign rdata_in[0] = mst_rdata_hi;
    assign rdata_in[1] = mst_rdata_lo;

    // Unit sequencing: entry fetch, then read and write per element
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            for (int u = 0; u < 2; u++) begin
                st[u] <= DMOV_IDLE;
                ev_num[u] <= 5'h00;
                src[u] <= `DMOV_RST_WORD;
                dst[u] <= `DMOV_RST_WORD;
                cnt[u] <= 16'h0000;
                sidx[u] <= 16'h0000;
                didx[u] <= 16'h0000;
                esize[u] <= 2'h0;
                sync_type[u] <= 2'h0;
                reload[u] <= 1'b0;
                data[u] <= `DMOV_RST_WORD;
            end
        end else begin
            for (int u = 0; u < 2; u++) begin
                case (st[u])
                    DMOV_IDLE: begin
                        if (dispatch[u]) begin
                            ev_num[u] <= pick[u][4:0];
                            st[u] <= DMOV_EVT;
                        end
                    end
                    DMOV_EVT: begin
                        esize[u] <= ee[u][`DMOV_EE_ESIZE];
                        sync_type[u] <= ee[u][`DMOV_EE_SYNC];
                        reload[u] <= ee[u][`DMOV_EE_RELOAD];
                        if (ee[u][`DMOV_EE_TYPE] == `DMOV_TYPE_XFER) begin
                            st[u] <= DMOV_LOAD;
                        end else begin
                            st[u] <= DMOV_IDLE;
                        end
                    end
                    DMOV_LOAD: begin
                        src[u] <= parameter_memory[te_base[u] | 7'(`DMOV_TE_SRC)];
                        dst[u] <= parameter_memory[te_base[u] | 7'(`DMOV_TE_DST)];
                        cnt[u] <= parameter_memory[te_base[u] | 7'(`DMOV_TE_CNT)][`DMOV_TE_COUNT];
                        sidx[u] <= parameter_memory[te_base[u] | 7'(`DMOV_TE_IDX)][`DMOV_TE_SIDX];
                        didx[u] <= parameter_memory[te_base[u] | 7'(`DMOV_TE_IDX)][`DMOV_TE_DIDX];
                        if (parameter_memory[te_base[u] | 7'(`DMOV_TE_CNT)][`DMOV_TE_COUNT]
                            == 16'h0000) begin
                            st[u] <= DMOV_FIN;
                        end else begin
                            st[u] <= DMOV_READ;
                        end
                    end
                    DMOV_READ: begin
                        if (mst_req[u] && mst_ack[u]) begin
                            data[u] <= rdata_in[u];
                            st[u] <= DMOV_WRITE;
                        end
                    end
                    DMOV_WRITE: begin
                        if (mst_req[u] && mst_ack[u]) begin
                            cnt[u] <= cnt[u] - 16'h0001;
                            src[u] <= src[u] + addr_step(sidx[u], esize[u]);
                            dst[u] <= dst[u] + addr_step(didx[u], esize[u]);
                            st[u] <= cnt[u] == 16'h0001 ? DMOV_FIN : DMOV_READ;
                        end
                    end
                    DMOV_FIN: st[u] <= DMOV_IDLE;
                    default: st[u] <= DMOV_IDLE;
                endcase
            end
        end
    end

    // Crossbar requests, held until acked or the low one blocked, dropped for one cycle between
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mst_req <= 2'b00;
            for (int u = 0; u < 2; u++) begin
                cmd[u] <= '0;
            end
        end else begin
            for (int u = 0; u < 2; u++) begin
                cmd[u].size <= esize[u];
                cmd[u].wdata <= data[u];
                if (st[u] == DMOV_READ) begin
                    cmd[u].we <= 1'b0;
                    cmd[u].addr <= src[u];
                end else if (st[u] == DMOV_WRITE) begin
                    cmd[u].we <= 1'b1;
                    cmd[u].addr <= dst[u];
                end
                if (mst_req[u] && mst_ack[u]) begin
                    mst_req[u] <= 1'b0;
                end else if (u == 1 && lo_blocked) begin
                    mst_req[u] <= 1'b0;
                end else begin
                    mst_req[u] <= st[u] == DMOV_READ || st[u] == DMOV_WRITE;
                end
            end
        end
    end
    assign mst_cmd_hi = cmd[0];
    assign mst_cmd_lo = cmd[1];

    // Interrupt-bound events pulse the named CPU line for one cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cpu_irq <= `DMOV_RST_IRQ;
        end else begin
            cpu_irq <= `DMOV_RST_IRQ;
            for (int u = 0; u < 2; u++) begin
                if (st[u] == DMOV_EVT && ee[u][`DMOV_EE_TYPE] == `DMOV_TYPE_INT) begin
                    cpu_irq[ee[u][`DMOV_EE_IRQ]] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Register read port, data valid the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= `DMOV_RST_WORD;
        end else if (reg_rd && pmem_hit) begin
            reg_rdata <= parameter_memory[pmem_idx];
        end else if (reg_rd) begin
            case (reg_addr)
                `DMOV_OFF_POL: reg_rdata <= polarity;
                `DMOV_OFF_EN_SET: reg_rdata <= enable;
                `DMOV_OFF_EN_CLR: reg_rdata <= enable;
                `DMOV_OFF_HI_SET: reg_rdata <= high_group;
                `DMOV_OFF_LO_SET: reg_rdata <= ~high_group;
                `DMOV_OFF_FLAG: reg_rdata <= event_flag_reg;
                `DMOV_OFF_STATE: reg_rdata <= event_state_reg;
                `DMOV_OFF_TRIG: reg_rdata <= soft_trigger_reg;
                `DMOV_OFF_DONE: reg_rdata <= done_reg;
                `DMOV_OFF_STATUS: reg_rdata <= {12'h000, ev_num[1], st[1],
                                                ev_num[0], st[0], sync_type[1], sync_type[0]};
                default: reg_rdata <= `DMOV_RST_WORD;
            endcase
        end else begin
            reg_rdata <= `DMOV_RST_WORD;
        end
    end

endmodule

// File: tb/dmov_top_sva.sv
// Checker for the mover: crossbar handshake, read port, interrupt pulses.
// Assumes binding to dmov_top; sees its ports only.
module dmov_top_sva (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [1:0] mst_req,
    input wire dmov_pkg::dmov_mcmd_t mst_cmd_hi,
    input wire dmov_pkg::dmov_mcmd_t mst_cmd_lo,
    input wire logic [1:0] mst_ack,
    input wire logic [15:0] cpu_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmov_pkg::*;
    // ========================================
    // Handshake and port timing
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic same;
    assign same = mst_cmd_hi.addr[31:28] == mst_cmd_lo.addr[31:28];
    a_hi_req_hold: assert property (mst_req[0] && !mst_ack[0] |=> mst_req[0] && $stable(mst_cmd_hi))
        else $error("high request not held");
    a_lo_req_hold: assert property (mst_req[1] && !mst_ack[1] && !(mst_req[0] && same)
        |=> mst_req[1] && $stable(mst_cmd_lo)) else $error("low request not held");
    a_hi_req_drop: assert property (mst_req[0] && mst_ack[0] |=> !mst_req[0])
        else $error("high request kept after ack");
    a_lo_req_drop: assert property (mst_req[1] && mst_ack[1] |=> !mst_req[1])
        else $error("low request kept after ack");
    a_high_first: assert property (mst_req[0] && !mst_ack[0] && mst_req[1] && same |=> !mst_req[1])
        else $error("low unit kept a contested slave");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_irq_pulse: assert property (cpu_irq != 16'h0 |=> cpu_irq == 16'h0)
        else $error("interrupt longer than one cycle");
    a_read_then_write: assert property (mst_req[0] && mst_ack[0] && !mst_cmd_hi.we
        |-> ##[2:3] mst_req[0] && mst_cmd_hi.we) else $error("no write after read");
endmodule

bind dmov_top dmov_top_sva i_sva (.mclk(mclk), .rst_n(rst_n), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mst_req(mst_req), .mst_cmd_hi(mst_cmd_hi),
    .mst_cmd_lo(mst_cmd_lo), .mst_ack(mst_ack), .cpu_irq(cpu_irq));

// File: tb/dmov_xbar_model.sv
// Crossbar slave model: word memory behind both mover units.
// Assumes the bench drives stall to slow the answers at random.
module dmov_xbar_model (
    input wire logic mclk,
    input wire logic [1:0] mst_req,
    input wire dmov_pkg::dmov_mcmd_t mst_cmd_hi,
    input wire dmov_pkg::dmov_mcmd_t mst_cmd_lo,
    input wire logic [1:0] stall,
    output logic [1:0] mst_ack,
    output logic [31:0] mst_rdata_hi,
    output logic [31:0] mst_rdata_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmov_pkg::*;
    logic [31:0] mem [logic [31:0]];
    dmov_mcmd_t c [2];
    logic [31:0] rd [2];
    logic [1:0] ack;
    assign mst_rdata_hi = rd[0];
    assign mst_rdata_lo = rd[1];
    initial begin
        mst_ack = 2'h0;
        rd = '{32'h0, 32'h0};
    end
    // ========================================
    // One ack per held request, read bus toggles when idle
    always @(posedge mclk) begin
        c = '{mst_cmd_hi, mst_cmd_lo};
        ack = mst_req & ~mst_ack & ~stall;
        if (ack == 2'h3 && same_slave(c[0].addr, c[1].addr)) begin
            ack[1] = 1'b0;
        end
        for (int u = 0; u < 2; u++) begin
            rd[u] <= ~rd[u];
            if (ack[u] && c[u].we) mem[c[u].addr] = c[u].wdata;
            if (ack[u] && !c[u].we && mem.exists(c[u].addr)) rd[u] <= mem[c[u].addr];
        end
        mst_ack <= ack;
    end
    function automatic logic same_slave(logic [31:0] a, logic [31:0] b);
        return a[31:28] == b[31:28];
    endfunction
endmodule

// File: tb/testbench.sv
// Bench for the mover: state mirror, edge capture, interrupts, transfers.
// Assumes the crossbar model on the far side of both units.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dmov_pkg::*;
    logic mclk, rst_n, reg_wr, reg_rd;
    logic [15:0] reg_addr, cpu_irq;
    logic [31:0] reg_wdata, reg_rdata, t, rdh, rdl;
    dmov_evin_t evin;
    dmov_mcmd_t cmd_hi, cmd_lo;
    logic [1:0] req, ack, stall;
    int bad_count, check_count, n;
    int tbit [10] = '{0, 16, 1, 17, 2, 18, 3, 19, 20, 21};
    int evn [10] = '{0, 1, 10, 11, 17, 18, 23, 24, 30, 31};
    dmov_top i_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .evin(evin), .mst_req(req),
        .mst_cmd_hi(cmd_hi), .mst_cmd_lo(cmd_lo), .mst_ack(ack), .mst_rdata_hi(rdh),
        .mst_rdata_lo(rdl), .cpu_irq(cpu_irq));
    dmov_xbar_model i_xbar (.mclk(mclk), .mst_req(req), .mst_cmd_hi(cmd_hi), .mst_cmd_lo(cmd_lo),
        .stall(stall), .mst_ack(ack), .mst_rdata_hi(rdh), .mst_rdata_lo(rdl));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) stall <= 2'($urandom);
    // ========================================
    // Expected state register from levels and trigger bits
    function automatic logic [31:0] smap(dmov_evin_t v, logic [31:0] s);
        return {s[21], s[20], v.timer_overflow_error,
            v.audio_mute_input | v.audio_tx_err | v.audio_rx_err, 1'b0, s[19], s[3],
            v.i2c_rx_evt[1], v.i2c_tx_evt[1], v.i2c_rx_evt[0], v.i2c_tx_evt[0], s[18], s[2],
            v.timer_request[3:2], v.spi_rx_req, v.host_port_interrupt, s[17], s[1],
            v.audio_rx_req[2], v.audio_tx_req[2], v.audio_rx_req[1], v.audio_tx_req[1],
            v.audio_rx_req[0], v.audio_tx_req[0], v.timer_request[1:0], s[16], s[0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check(reg_rdata, e);
    endtask
    task automatic wirq(input logic [15:0] e);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (cpu_irq === 16'h0 && n < 30);
        check({16'h0, cpu_irq}, {16'h0, e});
    endtask
    task automatic xent(input logic [15:0] b, input logic [31:0] sa, input logic [31:0] da);
        wr(b, sa);
        wr(b + 16'h4, da);
        wr(b + 16'h8, 32'h2);
        wr(b + 16'hc, 32'h0001_0001);
        i_xbar.mem[sa] = $urandom;
        i_xbar.mem[sa + 4] = $urandom;
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'h5dd2));
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, evin, t} = '0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rd(16'h0008, 32'h0);
        rd(16'h0018, 32'hffff_ffff);
        rd(16'h0004, 32'h0);
        repeat (4) begin
            @(posedge mclk);
            evin <= dmov_evin_t'($urandom);
            t = $urandom;
            wr(16'h0038, t);
            rd(16'h0034, smap(evin, t));
        end
        @(posedge mclk);
        evin <= '0;
        t = 0;
        wr(16'h0038, t);
        // Every trigger bit raises its interrupt, groups alternating
        for (int k = 0; k < 10; k++) begin
            n = evn[k];
            wr(((k % 2) ? 16'h1000 : 16'h1100) + 16'(4 * n), {16'h0, 4'(n), 12'h002});
            if (k % 2) wr(16'h0014, 32'h1 << n);
            wr(16'h000c, 32'h1 << n);
            t[tbit[k]] = 1'b1;
            wr(16'h0038, t);
            wirq(16'h1 << evn[k][3:0]);
        end
        // Falling polarity on event 0 only, event 1 stays rising
        wr(16'h0008, 32'h1);
        t = t & ~32'h0001_0001;
        wr(16'h0038, t);
        wirq(16'h0001);
        rd(16'h001c, 32'h0);
        // Concurrent transfers, low source on the high destination slave
        wr(16'h0008, 32'h0);
        wr(16'h1004, 32'h0000_0751);
        xent(16'h10f0, 32'h1000_0000, 32'h2000_0000);
        wr(16'h1100, 32'h0000_0051);
        xent(16'h1180, 32'h2000_0100, 32'h4000_0000);
        wr(16'h0038, t | 32'h0001_0001);
        repeat (300) @(negedge mclk);
        for (int j = 0; j < 8; j += 4) begin
            check(i_xbar.mem[32'h2000_0000 + j], i_xbar.mem[32'h1000_0000 + j]);
            check(i_xbar.mem[32'h4000_0000 + j], i_xbar.mem[32'h2000_0100 + j]);
        end
        rd(16'h0080, 32'h3);
        stop_test();
    end
endmodule
